// File: strap_cfg_pkg.sv
// shared constants and types for the strap capture block
package strap_cfg_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_LANES  = 8'h0C;

  // host data pin positions of the straps
  localparam int BOOT_LO_BIT     = 3;
  localparam int BYTE_ORDER_BIT  = 8;
  localparam int LANE_FIX_BIT    = 12;
  localparam int HOST_EN_BIT     = 14;
  localparam int HOST_DATA_WIDTH = 16;

  // values held until capture (the pulled defaults)
  localparam logic [1:0] BOOT_RESET     = 2'h1;
  localparam logic       LITTLE_RESET   = 1'b1;
  localparam logic       LANE_FIX_RESET = 1'b1;
  localparam logic       HOST_EN_RESET  = 1'b1;
  localparam logic [1:0] MODE_RESET     = 2'h3;

  // status register field positions
  localparam int ST_BOOT_LO  = 0;
  localparam int ST_LITTLE   = 2;
  localparam int ST_LANE_FIX = 3;
  localparam int ST_HOST_EN  = 4;
  localparam int ST_MODE_LO  = 5;
  localparam int ST_CAPTURED = 7;
  localparam int ST_FUNC     = 8;
  localparam int ST_RESERVED = 9;
  localparam int ST_CLK_BAD  = 10;

  // boot source codes
  localparam logic [1:0] BOOT_HOST  = 2'h0;
  localparam logic [1:0] BOOT_ROM8  = 2'h1;
  localparam logic [1:0] BOOT_ROM16 = 2'h2;
  localparam logic [1:0] BOOT_ROM32 = 2'h3;

  // debug mode pin codes
  localparam logic [1:0] MODE_SCAN = 2'h0;
  localparam logic [1:0] MODE_EMU  = 2'h3;

  typedef enum logic [0:0] {
    CAP_WAIT = 1'b0,
    CAP_DONE = 1'b1
  } phase_t;

  typedef enum logic [1:0] {
    SIZE_8  = 2'b00,
    SIZE_16 = 2'b01,
    SIZE_32 = 2'b10
  } acc_size_t;

  localparam logic [1:0] SIZE_RESET = 2'b10;

endpackage

// File: lane_cfg_if.sv
// carries lane setup and data between control and lane steering
`timescale 1ns/10ps
interface lane_cfg_if;
  import strap_cfg_pkg::*;
  logic        little;
  logic        lane_fix;
  acc_size_t   size;
  logic [31:0] data;
  logic [31:0] steered;
  modport ctrl  (output little, output lane_fix, output size, output data, input steered);
  modport steer (input little, input lane_fix, input size, input data, output steered);
endinterface

// File: strap_sync.sv
// two-stage synchroniser for strap pins, free running through reset
`timescale 1ns/10ps
module strap_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // no reset so the chain tracks the pins while reset is held
  always_ff @(posedge clk_i) begin
    stage1 <= async_i;
    stage2 <= stage1;
  end

  assign sync_o = stage2;
endmodule

// File: lane_steer.sv
// places narrow external memory data on the correct byte lanes
`timescale 1ns/10ps
module lane_steer
  import strap_cfg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic resetn_i,
  lane_cfg_if.steer lanes
);
  // steer 8 and 16 bit data to low or high lanes
  function automatic logic [31:0] steer(input logic [31:0] d, input acc_size_t s,
                                        input logic little, input logic fix);
    logic high;
    high = fix && !little;
    unique case (s)
      SIZE_8:  steer = high ? {d[7:0], 24'h000000} : {24'h000000, d[7:0]};
      SIZE_16: steer = high ? {d[15:0], 16'h0000} : {16'h0000, d[15:0]};
      default: steer = d;
    endcase
  endfunction

  // lane choice follows correction and order straps
  always_comb begin
    lanes.steered = steer(lanes.data, lanes.size, lanes.little, lanes.lane_fix); // [R4] [R5]
  end

  low_lane_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
    (!lanes.lane_fix && lanes.size == SIZE_8) |-> lanes.steered == {24'h000000, lanes.data[7:0]})
    else $error("narrow data left the low lane with correction off");

  big_lane_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
    (lanes.lane_fix && !lanes.little && lanes.size == SIZE_16)
      |-> lanes.steered == {lanes.data[15:0], 16'h0000})
    else $error("big order half word not on the high lanes");
endmodule

// File: strap_config_top.sv
// strap capture at reset release, mode decode and bus access
// Function
// [R1] host data pins act as mode straps during reset
// [R2] pins 4:3 pick boot source, default 8-bit ROM
// [R3] pin 8 picks byte order, 1 little
// [R4] lane fix 0 keeps narrow data low
// [R5] lane fix 1 moves big order data high
// [R6] pin 14 gives shared pins to host port
// [R7] host port off only with external pulldown
// [R8] debug pins 00 scan, 11 emulation, others reserved
// [R9] functional operation in scan or emulation mode
// [R10] board drives debug pins and reset low for scan
// [R11] board leaves test reset at its pulldown
// [R12] board holds clock source select at one
// [R13] board keeps non-strap pins at defaults in reset
// [R14] pins 15,6,5,2 may be driven freely
// [R15] captured straps held until the next reset
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module strap_config_top
  import strap_cfg_pkg::*;
#(
  parameter int HD_WIDTH = HOST_DATA_WIDTH
) (
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic [HD_WIDTH-1:0] host_data_pins_i,
  input  wire logic [1:0]          debug_mode_pins_i,
  input  wire logic                clock_source_select_i,
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic      [31:0]         hrdata_o,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  output logic [1:0]               boot_source_o,
  output logic                     little_order_flag_o,
  output logic                     narrow_lane_select_o,
  output logic                     host_port_enable_o,
  output logic                     audio_port_enable_o,
  output logic                     boundary_scan_mode_o,
  output logic                     emulation_mode_o,
  output logic                     functional_enable_o,
  output logic                     mode_reserved_o,
  output logic                     config_valid_o,
  output logic [31:0]              ext_mem_data_bus_o
);

  localparam int SYNC_W = HD_WIDTH + 3;

  typedef struct packed {
    phase_t      phase;
    logic [1:0]  boot;
    logic        little;
    logic        lane_fix;
    logic        host_en;
    logic [1:0]  mode;
    logic        clk_bad;
    logic        audio_en;
    logic        scan;
    logic        emu;
    logic        func;
    logic        rsvd;
    acc_size_t   size;
    logic [31:0] wdata;
    logic [31:0] ext_data;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        ready;
  } state_t;

  state_t           st;
  state_t           next_st;
  logic [SYNC_W-1:0] pins_sync;
  logic [HD_WIDTH-1:0] hd_sync;
  logic [1:0]       mode_sync;
  logic             clksel_sync;
  logic             addr_phase;
  logic [31:0]      status_word;

  lane_cfg_if lanes ();

  // every strap pin passes two flops before use
  strap_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .async_i ({clock_source_select_i, debug_mode_pins_i, host_data_pins_i}),
    .sync_o  (pins_sync)
  );

  assign hd_sync     = pins_sync[HD_WIDTH-1:0];
  assign mode_sync   = pins_sync[HD_WIDTH+1:HD_WIDTH];
  assign clksel_sync = pins_sync[HD_WIDTH+2];

  // narrow access lane steering
  lane_steer u_steer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .lanes    (lanes)
  );

  assign lanes.little   = st.little;
  assign lanes.lane_fix = st.lane_fix;
  assign lanes.size     = st.size;
  assign lanes.data     = st.wdata;

  // functional operation allowed in scan or emulation mode
  function automatic logic mode_functional(input logic [1:0] m);
    mode_functional = (m == MODE_SCAN) || (m == MODE_EMU); // [R9]
  endfunction

  // codes 01 and 10 are not usable
  function automatic logic mode_reserved(input logic [1:0] m);
    mode_reserved = !mode_functional(m); // [R8]
  endfunction

  assign addr_phase = hsel_i && htrans_i[1] && hready_i;

  // read view of the captured configuration
  always_comb begin
    status_word                            = 32'h00000000;
    status_word[ST_BOOT_LO+1:ST_BOOT_LO]   = st.boot;
    status_word[ST_LITTLE]                 = st.little;
    status_word[ST_LANE_FIX]               = st.lane_fix;
    status_word[ST_HOST_EN]                = st.host_en;
    status_word[ST_MODE_LO+1:ST_MODE_LO]   = st.mode;
    status_word[ST_CAPTURED]               = (st.phase == CAP_DONE);
    status_word[ST_FUNC]                   = st.func;
    status_word[ST_RESERVED]               = st.rsvd;
    status_word[ST_CLK_BAD]                = st.clk_bad;
  end

  // next state: capture once, then serve the bus
  always_comb begin
    next_st          = st;
    next_st.ready    = 1'b1;
    next_st.ext_data = lanes.steered;
    unique case (st.phase)
      CAP_WAIT: begin
        // first edge after release sees the levels held during reset
        next_st.boot     = hd_sync[BOOT_LO_BIT+1:BOOT_LO_BIT]; // [R1] [R2]
        next_st.little   = hd_sync[BYTE_ORDER_BIT]; // [R3]
        next_st.lane_fix = hd_sync[LANE_FIX_BIT]; // [R4] [R5]
        next_st.host_en  = hd_sync[HOST_EN_BIT]; // [R6] [R7]
        next_st.audio_en = !hd_sync[HOST_EN_BIT]; // [R6]
        next_st.mode     = mode_sync; // [R8]
        next_st.scan     = (mode_sync == MODE_SCAN); // [R8]
        next_st.emu      = (mode_sync == MODE_EMU); // [R8]
        next_st.func     = mode_functional(mode_sync); // [R9]
        next_st.rsvd     = mode_reserved(mode_sync); // [R8]
        next_st.clk_bad  = !clksel_sync;
        next_st.phase    = CAP_DONE;
      end
      CAP_DONE: begin
        next_st.phase = CAP_DONE; // [R15]
      end
    endcase
    // data phase of a write
    if (st.wr_pend) begin
      next_st.wr_pend = 1'b0;
      if (st.wr_addr == ADDR_CTRL) begin
        if (hwdata_i[1:0] == SIZE_8 || hwdata_i[1:0] == SIZE_16) begin
          next_st.size = acc_size_t'(hwdata_i[1:0]);
        end else begin
          next_st.size = SIZE_32;
        end
      end else if (st.wr_addr == ADDR_DATA) begin
        next_st.wdata = hwdata_i;
      end
    end
    // address phase: latch write, prepare read data
    if (addr_phase) begin
      next_st.wr_pend = hwrite_i;
      next_st.wr_addr = haddr_i[7:0];
      next_st.rdata   = 32'h00000000;
      if (!hwrite_i && haddr_i[31:8] == 24'h000000) begin
        unique case (haddr_i[7:0])
          ADDR_STATUS: next_st.rdata = status_word;
          ADDR_CTRL:   next_st.rdata = {30'h00000000, st.size};
          ADDR_DATA:   next_st.rdata = st.wdata;
          ADDR_LANES:  next_st.rdata = st.ext_data;
          default:     next_st.rdata = 32'h00000000;
        endcase
      end
      if (haddr_i[31:8] != 24'h000000) begin
        next_st.wr_pend = 1'b0;
      end
    end
  end

  // state register, defaults are the pulled strap levels
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st.phase    <= CAP_WAIT;
      st.boot     <= BOOT_RESET;
      st.little   <= LITTLE_RESET;
      st.lane_fix <= LANE_FIX_RESET;
      st.host_en  <= HOST_EN_RESET;
      st.mode     <= MODE_RESET;
      st.clk_bad  <= 1'b0;
      st.audio_en <= 1'b0;
      st.scan     <= 1'b0;
      st.emu      <= 1'b1;
      st.func     <= 1'b1;
      st.rsvd     <= 1'b0;
      st.size     <= SIZE_32;
      st.wdata    <= 32'h00000000;
      st.ext_data <= 32'h00000000;
      st.wr_pend  <= 1'b0;
      st.wr_addr  <= 8'h00;
      st.rdata    <= 32'h00000000;
      st.ready    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register, hresp_o tied low
  assign hrdata_o             = st.rdata;
  assign hreadyout_o          = st.ready;
  assign hresp_o              = 1'b0;
  assign boot_source_o        = st.boot;
  assign little_order_flag_o  = st.little;
  assign narrow_lane_select_o = st.lane_fix;
  assign host_port_enable_o   = st.host_en;
  assign audio_port_enable_o  = st.audio_en;
  assign boundary_scan_mode_o = st.scan;
  assign emulation_mode_o     = st.emu;
  assign functional_enable_o  = st.func;
  assign mode_reserved_o      = st.rsvd;
  assign config_valid_o       = (st.phase == CAP_DONE) ? 1'b1 : 1'b0;
  assign ext_mem_data_bus_o   = st.ext_data;

  // release edge excluded: reset is still sampled low there, capture is one edge later
  strap_source_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R1]
    (st.phase == CAP_WAIT && resetn_i) |=> (st.boot == $past(hd_sync[4:3])
      && st.host_en == $past(hd_sync[14])))
    else $error("captured straps differ from pin levels");

  boot_capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R2]
    $rose(config_valid_o) |-> boot_source_o == $past(hd_sync[4:3]))
    else $error("boot source not taken from pins 4:3");

  byte_order_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R3]
    $rose(config_valid_o) |-> little_order_flag_o == $past(hd_sync[8]))
    else $error("byte order not taken from pin 8");

  host_share_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R6]
    config_valid_o |-> (audio_port_enable_o == !host_port_enable_o))
    else $error("shared pins owned by both or neither port");

  host_default_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R7]
    !config_valid_o |-> host_port_enable_o && !audio_port_enable_o)
    else $error("host port not enabled before capture");

  mode_decode_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R8]
    config_valid_o |-> (boundary_scan_mode_o == (st.mode == 2'h0))
      && (emulation_mode_o == (st.mode == 2'h3))
      && (mode_reserved_o == (st.mode == 2'h1 || st.mode == 2'h2)))
    else $error("debug mode decode wrong");

  functional_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R9]
    functional_enable_o == (boundary_scan_mode_o || emulation_mode_o))
    else $error("functional enable disagrees with mode");

  capture_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R15]
    config_valid_o |=> config_valid_o && $stable(boot_source_o)
      && $stable(little_order_flag_o) && $stable(narrow_lane_select_o)
      && $stable(host_port_enable_o) && $stable(st.mode))
    else $error("captured configuration changed after capture");

  lane_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
    (config_valid_o && !narrow_lane_select_o && st.size == SIZE_16)
      |=> ext_mem_data_bus_o[31:16] == 16'h0000)
    else $error("half word left the low lanes with correction off");

  // configuration becomes valid one edge after reset is sampled high
  capture_edge_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R1]
    (resetn_i && !config_valid_o) |=> config_valid_o)
    else $error("configuration not captured at first edge after release");

  lane_capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
    $rose(config_valid_o) |-> narrow_lane_select_o == $past(hd_sync[LANE_FIX_BIT]))
    else $error("lane correction not taken from pin 12");

  host_capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R6]
    $rose(config_valid_o) |-> host_port_enable_o == $past(hd_sync[HOST_EN_BIT])
      && audio_port_enable_o == !$past(hd_sync[HOST_EN_BIT]))
    else $error("shared pin owner not taken from pin 14");

  mode_capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R8]
    $rose(config_valid_o) |-> st.mode == $past(mode_sync))
    else $error("debug mode not taken from its pins");

  low_byte_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
    (config_valid_o && !narrow_lane_select_o && st.size == SIZE_8)
      |=> ext_mem_data_bus_o[31:8] == 24'h000000)
    else $error("byte left the low lane with correction off");

  high_byte_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
    (config_valid_o && narrow_lane_select_o && !little_order_flag_o && st.size == SIZE_8)
      |=> ext_mem_data_bus_o[23:0] == 24'h000000)
    else $error("big order byte not on the high lane");

endmodule

// File: board_strap_model.sv
// board side of the straps: pull resistors and an external host controller
`timescale 1ns/10ps
module board_strap_model (
  input  wire logic [15:0] drv_en_i,
  input  wire logic [15:0] drv_val_i,
  input  wire logic [1:0]  dbg_val_i,
  output logic      [15:0] host_data_pins_o,
  output logic      [1:0]  debug_mode_pins_o,
  output logic             clock_source_select_o
);
  // pin 4 has a pulldown, every other host data pin a pullup
  localparam logic [15:0] PULL_LEVEL = 16'hFFEF;
  // pins 13, 11:9, 7, 1, 0 are never opposed by the controller
  localparam logic [15:0] FIXED_PINS = 16'h2E83;

  // controller drives straps and free pins 15,6,5,2; fixed pins stay at pull level
  assign host_data_pins_o = (drv_en_i & ~FIXED_PINS & drv_val_i)
                          | ((~drv_en_i | FIXED_PINS) & PULL_LEVEL);
  // debug pins follow dbg_val_i, 00 for scan, 11 for emulation, other codes also driven; test reset left alone
  assign debug_mode_pins_o = dbg_val_i;
  // clock source select held at the square wave setting
  assign clock_source_select_o = 1'b1;
endmodule

// File: test_reset_strap_config_capture.sv
// self-checking bench for the strap capture block
`timescale 1ns/10ps
module test_reset_strap_config_capture;
  import strap_cfg_pkg::*;
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic [15:0] drv_en   = 16'h0000;
  logic [15:0] drv_val  = 16'h0000;
  logic [1:0]  dbg_val  = 2'h3;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h00000000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h00000000;
  logic [15:0] pins;
  logic [1:0]  dbg_pins;
  logic        clk_sel;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  boot;
  logic        little, lane_sel, host_en, audio_en, scan, emu, func, reserved, valid;
  logic [31:0] ext_bus;
  logic [10:0] outs;
  int          fail_count = 0;
  int          num_checks = 0;

  // clock at 25 ns period
  always #12.5 clk_i = ~clk_i;

  assign outs = {boot, little, lane_sel, host_en, audio_en, scan, emu, func, reserved, valid};

  board_strap_model i_board_strap_model (
    .drv_en_i(drv_en), .drv_val_i(drv_val), .dbg_val_i(dbg_val),
    .host_data_pins_o(pins), .debug_mode_pins_o(dbg_pins), .clock_source_select_o(clk_sel)
  );

  strap_config_top i_strap_config_top (
    .clk_i(clk_i), .resetn_i(resetn_i), .host_data_pins_i(pins),
    .debug_mode_pins_i(dbg_pins), .clock_source_select_i(clk_sel),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .boot_source_o(boot),
    .little_order_flag_o(little), .narrow_lane_select_o(lane_sel),
    .host_port_enable_o(host_en), .audio_port_enable_o(audio_en),
    .boundary_scan_mode_o(scan), .emulation_mode_o(emu), .functional_enable_o(func),
    .mode_reserved_o(reserved), .config_valid_o(valid), .ext_mem_data_bus_o(ext_bus)
  );

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // reset with given straps, check capture, status and hold after pins move
  task automatic capture(input logic [15:0] en, input logic [1:0] bt, input logic lt,
                         input logic ln, input logic he, input logic [1:0] md);
    logic [15:0] v;
    logic [10:0] exp;
    logic [31:0] rd;
    v = {1'b0, he, 1'b0, ln, 3'h0, lt, 3'h0, bt, 3'h0};
    exp = {bt, lt, ln, he, ~he, md == MODE_SCAN, md == MODE_EMU,
           md == MODE_SCAN || md == MODE_EMU, md == 2'h1 || md == 2'h2, 1'b1};
    @(posedge clk_i);
    drv_en <= en;
    drv_val <= v;
    dbg_val <= md;
    resetn_i <= 1'b0;
    repeat (19) @(posedge clk_i);
    #1;
    chk({31'h0, valid}, 32'h0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({21'h0, outs}, {21'h0, exp});
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    bus(1'b0, {24'h0, ADDR_STATUS}, 32'h0, rd);
    chk(rd, {21'h0, 1'b0, exp[1], exp[2], 1'b1, md, he, ln, lt, bt});
    @(posedge clk_i);
    drv_en <= 16'hFFFF;
    drv_val <= ~v;
    dbg_val <= ~md;
    repeat (5) @(posedge clk_i);
    #1;
    chk({21'h0, outs}, {21'h0, exp});
  endtask

  // narrow data placement for each access size
  task automatic lanes(input logic lt, input logic ln);
    logic [31:0] rd;
    logic [31:0] exp;
    logic        hi;
    hi = ln && !lt;
    capture(16'hFFFF, BOOT_ROM32, lt, ln, 1'b1, MODE_EMU);
    bus(1'b0, {24'h0, ADDR_CTRL}, 32'h0, rd);
    chk(rd, {30'h0, SIZE_RESET});
    bus(1'b1, {24'h0, ADDR_DATA}, 32'hA1B2C3D4, rd);
    for (int s = 0; s < 3; s++) begin
      case (s)
        0: exp = hi ? 32'hD4000000 : 32'h000000D4;
        1: exp = hi ? 32'hC3D40000 : 32'h0000C3D4;
        default: exp = 32'hA1B2C3D4;
      endcase
      bus(1'b1, {24'h0, ADDR_CTRL}, 32'(s), rd);
      bus(1'b0, {24'h0, ADDR_LANES}, 32'h0, rd);
      chk(rd, exp);
      chk(ext_bus, exp);
    end
  endtask

  // unmapped and aliased addresses read zero and ignore writes
  task automatic unmapped;
    logic [31:0] rd;
    bus(1'b1, 32'h00000010, 32'h5A5A5A5A, rd);
    bus(1'b0, 32'h00000010, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, 32'h00000104, 32'h00000000, rd);
    bus(1'b0, 32'h00000100, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, {24'h0, ADDR_CTRL}, 32'h0, rd);
    chk(rd, 32'h00000002);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    capture(16'h0000, BOOT_ROM8, 1'b1, 1'b1, 1'b1, MODE_EMU);
    for (int i = 0; i < 4; i++) begin
      capture(16'hFFFF, i[1:0], i[0], i[1], ~i[0], i[1:0]);
    end
    for (int i = 0; i < 4; i++) begin
      lanes(i[0], i[1]);
    end
    unmapped();
    print_verdict();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    print_verdict();
  end
endmodule
